// [sadc_conv_ctrl.sv]
// control of an 8-bit successive-approximation converter
`timescale 1ns/1ns
module sadc_conv_ctrl
    import sadc_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // host strobes, asynchronous pins
    input  wire logic             cs_n,
    input  wire logic             wr_n,
    input  wire logic             rd_n,
    // comparator: high when input is at or above the trial tap
    input  wire logic             comp_above,
    // trial code to the ladder switches
    output logic [RES_W-1:0]      trial_code,
    // three-state data bus, bit 0 is result_bit_lsb, bit 7 result_bit_msb
    output logic [RES_W-1:0]      data_bus_out,
    output logic                  data_bus_oe_n,
    // conversion done, active low
    output logic                  conv_done_n
);

    logic                   conv_tick;
    logic [SYNC_STAGES-1:0] cs_sync_r;
    logic [SYNC_STAGES-1:0] wr_sync_r;
    logic [SYNC_STAGES-1:0] rd_sync_r;
    logic [SYNC_STAGES-1:0] cmp_sync_r;
    logic                   cs_n_s;
    logic                   wr_n_s;
    logic                   rd_n_s;
    logic                   cmp_s;
    logic                   cs_prev_r;
    logic                   wr_prev_r;
    logic                   hold_rst;
    logic                   cs_fall;
    logic                   wr_fall;
    logic                   read_act;
    logic                   start_r;
    logic                   start_q_r;
    logic                   launch;
    logic                   finish;
    logic [RES_W-1:0]       mark_r;
    logic [PH_W-1:0]        phase_r;
    logic [RES_W-1:0]       sar_r;
    logic                   end_r;
    logic                   done_r;
    logic [RES_W-1:0]       result_r;

    // trial value: bits decided so far plus the bit under test
    function automatic logic [RES_W-1:0] trial_of(input logic [RES_W-1:0] sar, input logic [RES_W-1:0] mark);
        trial_of = sar | mark;
    endfunction

    sadc_tick_gen u_tick (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .conv_tick (conv_tick)
    );

    // two-stage synchronisers; only the second stage is read by logic
    // the comparator is sampled too, its decision settles off this clock
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cs_sync_r  <= '1;
            wr_sync_r  <= '1;
            rd_sync_r  <= '1;
            cmp_sync_r <= '0;
        end else begin
            cs_sync_r  <= {cs_sync_r[0], cs_n};
            wr_sync_r  <= {wr_sync_r[0], wr_n};
            rd_sync_r  <= {rd_sync_r[0], rd_n};
            cmp_sync_r <= {cmp_sync_r[0], comp_above};
        end
    end

    assign cs_n_s = cs_sync_r[SYNC_STAGES-1];
    assign wr_n_s = wr_sync_r[SYNC_STAGES-1];
    assign rd_n_s = rd_sync_r[SYNC_STAGES-1];
    assign cmp_s  = cmp_sync_r[SYNC_STAGES-1];

    // previous strobe levels for edge detection
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cs_prev_r <= 1'b1;
            wr_prev_r <= 1'b1;
        end else begin
            cs_prev_r <= cs_n_s;
            wr_prev_r <= wr_n_s;
        end
    end

    // strobe decode
    assign hold_rst = !cs_n_s && !wr_n_s;
    assign cs_fall  = cs_prev_r && !cs_n_s;
    assign wr_fall  = wr_prev_r && !wr_n_s;
    assign read_act = !cs_n_s && !rd_n_s;
    // launch once the start stage has gone high and a strobe has risen
    assign launch   = conv_tick && start_q_r && !hold_rst;
    // completion of the search; a held reset voids it for latch and flag alike
    assign finish   = conv_tick && end_r && !hold_rst;

    // start flip-flop: set while both strobes low, self-reset on launch
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            start_r <= 1'b0;
        end else if (hold_rst) begin
            start_r <= 1'b1;
        end else if (launch) begin
            start_r <= 1'b0;
        end
    end

    // second start stage follows on the conversion clock
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            start_q_r <= 1'b0;
        end else if (launch) begin
            start_q_r <= 1'b0;
        end else if (conv_tick) begin
            start_q_r <= start_r;
        end
    end

    // sequencing marker and phase within each step; strobes reset it
    // at core rate so a short write pulse is never missed
    always_ff @(posedge core_clk) begin
        if (!rst_b || hold_rst || wr_fall || cs_fall) begin
            mark_r  <= RES_ZERO;
            phase_r <= PH_ZERO;
        end else if (launch) begin
            mark_r  <= MARK_FIRST;
            phase_r <= PH_ZERO;
        end else if (conv_tick && mark_r != RES_ZERO) begin
            phase_r <= phase_r + PH_W'(1);
            if (phase_r == PH_LAST) begin
                mark_r <= mark_r >> 1;
            end
        end
    end

    // approximation register: keep the tested bit if input is at or above it
    always_ff @(posedge core_clk) begin
        if (!rst_b || hold_rst || wr_fall || cs_fall) begin
            sar_r <= RES_ZERO;
        end else if (launch) begin
            sar_r <= RES_ZERO;
        end else if (conv_tick && mark_r != RES_ZERO && phase_r == PH_LAST && cmp_s) begin
            sar_r <= sar_r | mark_r;
        end
    end

    // marks the period after the last bit has been decided
    always_ff @(posedge core_clk) begin
        if (!rst_b || hold_rst || wr_fall || cs_fall) begin
            end_r <= 1'b0;
        end else if (conv_tick) begin
            end_r <= mark_r[0] && phase_r == PH_LAST;
        end
    end

    // output latch only moves at the end of a conversion, never on reads
    // shares the done condition so the bus never shows an unannounced result
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            result_r <= RES_ZERO;
        end else if (finish) begin
            result_r <= sar_r;
        end
    end

    // done flag; a completion wins over a read that clears it
    // both strobes low outrank the completion, as they hold the reset state
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            done_r <= 1'b0;
        end else if (finish) begin
            done_r <= 1'b1;
        end else if (hold_rst || read_act) begin
            done_r <= 1'b0;
        end
    end

    // registered bus data; enable decodes the synchronised strobes without a register of its own
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            data_bus_out <= RES_ZERO;
        end else begin
            data_bus_out <= result_r;
        end
    end

    // trial code to the ladder; while idle it holds the decided bits, zero after reset, a strobe clear or a zero result
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            trial_code <= RES_ZERO;
        end else begin
            trial_code <= trial_of(sar_r, mark_r);
        end
    end

    assign data_bus_oe_n = !(rst_b && read_act);
    assign conv_done_n   = !done_r;

endmodule

// [sadc_conv_ctrl_asserts.sv]
// port assertions for the conversion control
`timescale 1ns/1ns
module sadc_chk
    import sadc_pkg::*;
(
    // clock and reset
    input wire logic             core_clk,
    input wire logic             rst_b,
    // strobes
    input wire logic             cs_n,
    input wire logic             wr_n,
    input wire logic             rd_n,
    // outputs
    input wire logic [RES_W-1:0] trial_code,
    input wire logic [RES_W-1:0] data_bus_out,
    input wire logic             data_bus_oe_n,
    input wire logic             conv_done_n
);
    localparam int LEN_MIN = 9984;
    localparam int LEN_MAX = 10296;
    logic [RES_W-1:0] prev_r;
    logic [15:0]      cyc_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // cycles since the marker appeared; too long for a repetition, so counted here
    always_ff @(posedge core_clk) begin
        prev_r <= trial_code;
        cyc_r  <= (prev_r == RES_ZERO && trial_code != RES_ZERO) ? 16'h0000 : cyc_r + 16'h0001;
    end
    bus_drive_a: assert property ((!cs_n && !rd_n) [*5] |-> !data_bus_oe_n)
        else $error("bus not driven during read");
    bus_release_a: assert property ((cs_n || rd_n) [*5] |-> data_bus_oe_n)
        else $error("bus not released");
    read_clear_a: assert property (!data_bus_oe_n |-> ##[0:2] conv_done_n)
        else $error("read did not clear done");
    done_kept_a: assert property ($rose(data_bus_oe_n) |-> conv_done_n [*3])
        else $error("done set again after read");
    reset_hold_a: assert property ((!cs_n && !wr_n) [*8] |-> trial_code == RES_ZERO && conv_done_n)
        else $error("converter left reset state");
    msb_first_a: assert property ($past(trial_code) == RES_ZERO && trial_code != RES_ZERO |-> trial_code == MARK_FIRST)
        else $error("search did not start at msb");
    latch_keep_a: assert property ($changed(data_bus_out) |-> !conv_done_n)
        else $error("latch changed without conversion");
    conv_len_a: assert property ($fell(conv_done_n) |-> cyc_r >= LEN_MIN && cyc_r <= LEN_MAX)
        else $error("conversion length wrong");
    abort_clear_a: assert property ($fell(cs_n) |-> ##[1:5] trial_code == RES_ZERO)
        else $error("select low did not abort");
endmodule
bind sadc_conv_ctrl sadc_chk sadc_chk_inst (.core_clk(core_clk), .rst_b(rst_b), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .trial_code(trial_code), .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n),
    .conv_done_n(conv_done_n));

// [sadc_front_model.sv]
// comparator model standing in for the analog ladder and input
`timescale 1ns/1ns
module sadc_front_model
    import sadc_pkg::*;
(
    // ladder side
    input  wire logic [RES_W-1:0] trial_code,
    input  wire logic [RES_W-1:0] vin,
    // comparator
    output logic                  comp_above
);
    // ideal comparator, a tap equal to the input keeps its bit so all ones is full scale
    assign comp_above = (vin >= trial_code);
endmodule

// [sadc_pkg.sv]
// shared constants for the successive-approximation conversion control
package sadc_pkg;

    // clock rates in hertz
    localparam int unsigned CORE_CLK_HZ = 100_000_000;
    localparam int unsigned CONV_CLK_HZ = 640_000;

    // core cycles per conversion clock period (rounded down, at least one)
    localparam int unsigned CONV_DIV_RAW = CORE_CLK_HZ / CONV_CLK_HZ;
    localparam int unsigned CONV_DIV     = (CONV_DIV_RAW < 1) ? 1 : CONV_DIV_RAW;
    localparam int unsigned DIV_W        = 8;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);

    // result width and search timing
    localparam int unsigned RES_W         = 8;
    localparam int unsigned CONV_PERIODS  = 64;
    localparam int unsigned STEP_PERIODS  = CONV_PERIODS / RES_W;
    localparam int unsigned PH_W          = 3;
    localparam logic [PH_W-1:0] PH_LAST   = PH_W'(STEP_PERIODS - 1);

    // field positions and reset values
    localparam int unsigned MSB_POS            = RES_W - 1;
    localparam logic [RES_W-1:0] MARK_FIRST    = 8'h80;
    localparam logic [RES_W-1:0] RES_ZERO      = 8'h00;
    localparam logic [PH_W-1:0]  PH_ZERO       = 3'h0;

    // pin synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;

endpackage

// [sadc_tick_gen.sv]
// divider that makes the one-cycle conversion clock enable
`timescale 1ns/1ns
module sadc_tick_gen
    import sadc_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // conversion clock enable
    output logic      conv_tick
);

    logic [DIV_W-1:0] div_cnt_r;

    // free-running count; the tick marks its wrap
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            div_cnt_r <= '0;
        end else if (div_cnt_r == DIV_LAST) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + DIV_W'(1);
        end
    end

    // one cycle high per conversion period
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            conv_tick <= 1'b0;
        end else begin
            conv_tick <= (div_cnt_r == DIV_LAST);
        end
    end

endmodule

// [tb.sv]
// self-checking bench for the conversion control
`timescale 1ns/1ns
module tb
    import sadc_pkg::*;
;
    logic             core_clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             cs_n = 1'b1;
    logic             wr_n = 1'b0; // low through power-up
    logic             rd_n = 1'b1;
    logic             free_run = 1'b0;
    logic             prev_done;
    logic [RES_W-1:0] vin = 8'h00;
    logic [RES_W-1:0] k;
    logic             comp_above;
    logic [RES_W-1:0] trial_code;
    logic [RES_W-1:0] data_bus_out;
    logic             data_bus_oe_n;
    logic             conv_done_n;
    logic [15:0]      rows [4] = '{16'h0000, 16'hFFFF, 16'hA5A5, 16'h5A5A};
    int               err_total = 0;
    int               samples_checked = 0;
    int               n;
    // 100 MHz clock
    always #5 core_clk = ~core_clk;
    // free-running loop ties done back to the write strobe
    always @(posedge core_clk) if (free_run) wr_n <= #1 conv_done_n;
    sadc_conv_ctrl sadc_conv_ctrl_inst (.core_clk(core_clk), .rst_b(rst_b), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .comp_above(comp_above), .trial_code(trial_code), .data_bus_out(data_bus_out),
        .data_bus_oe_n(data_bus_oe_n), .conv_done_n(conv_done_n));
    sadc_front_model sadc_front_model_inst (.trial_code(trial_code), .vin(vin), .comp_above(comp_above));
    // inputs move 1 ns after the edge so sampling never races
    task automatic step(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic check(input logic [RES_W-1:0] g, input logic [RES_W-1:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("checked=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // start a conversion, bounded waits for launch and done
    task automatic convert(input logic [RES_W-1:0] v);
        vin = v;
        cs_n = 1'b0;
        wr_n = 1'b0;
        step(160);
        check({7'h00, conv_done_n}, 8'h01);
        check(trial_code, RES_ZERO);
        wr_n = 1'b1;
        cs_n = 1'b1;
        for (n = 0; n < 1260 && trial_code === RES_ZERO; n++) step(1);
        check({7'h00, n < 1260}, 8'h01);
        for (n = 0; n < 12000 && conv_done_n !== 1'b0; n++) step(1);
        if (n == 12000) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic read_check(input logic [RES_W-1:0] e);
        cs_n = 1'b0;
        rd_n = 1'b0;
        step(5);
        check({7'h00, data_bus_oe_n}, 8'h00);
        check(data_bus_out, e);
        check({7'h00, conv_done_n}, 8'h01);
        rd_n = 1'b1;
        step(5);
        check({6'h00, data_bus_oe_n, conv_done_n}, 8'h03);
        cs_n = 1'b1;
        step(2);
    endtask
    initial begin
        step(6);
        check({6'h00, data_bus_oe_n, conv_done_n}, 8'h03);
        rst_b = 1'b1;
        step(2);
        $display("test reset done");
        // table rows: input code beside the expected result
        for (int i = 0; i < 4; i++) begin
            convert(rows[i][15:8]);
            read_check(rows[i][7:0]);
            $display("test row %0d done", i);
        end
        // write strobe alone in mid-search clears the search
        cs_n = 1'b0;
        wr_n = 1'b0;
        step(160);
        wr_n = 1'b1;
        cs_n = 1'b1;
        step(3000);
        check({7'h00, trial_code != RES_ZERO}, 8'h01);
        wr_n = 1'b0;
        step(8);
        check(trial_code, RES_ZERO);
        wr_n = 1'b1;
        step(2);
        $display("test write clear done");
        // abort in mid-search by taking select low alone
        vin = 8'h33;
        cs_n = 1'b0;
        wr_n = 1'b0;
        step(160);
        wr_n = 1'b1;
        cs_n = 1'b1;
        step(3000);
        cs_n = 1'b0;
        step(11000);
        check({7'h00, conv_done_n}, 8'h01);
        check(trial_code, RES_ZERO);
        cs_n = 1'b1;
        step(2);
        read_check(8'h5A);
        $display("test abort done");
        // free-running: select held low, done drives the write strobe
        cs_n = 1'b0;
        wr_n = 1'b0;
        step(160);
        free_run = 1'b1;
        k = 8'h00;
        prev_done = conv_done_n;
        repeat (23500) begin
            step(1);
            if (prev_done === 1'b1 && conv_done_n === 1'b0) k = k + 8'h01;
            prev_done = conv_done_n;
        end
        check(k, 8'h02);
        $display("test free run done");
        summarize();
    end
endmodule
